// [core/dftm_pkg.sv]
/*
  constants for the drive fault trip manager: trip indexes, categories,
  register offsets, field positions, reset values and timing counts.
  assumes one 250 MHz system clock.
*/
package dftm_pkg;
  // ----------------------------------------
  // trips
  // ----------------------------------------
  localparam int NTRIP = 16;
  localparam int T_FAN = 0;
  localparam int T_THM = 1;
  localparam int T_OSPD = 2;
  localparam int T_DEV = 3;
  localparam int T_ENC = 4;
  localparam int T_PID = 5;
  localparam int T_BRK = 6;
  localparam int T_KPD = 7;
  localparam int T_CMD = 8;
  localparam int T_OPT1 = 9;
  localparam int T_IOB = 12;
  localparam int T_PRM = 13;
  localparam int T_NTC = 14;
  localparam int T_HWD = 15;
  localparam logic [15:0] LEVEL_MASK = 16'h0180;
  localparam logic [15:0] FATAL_MASK = 16'h8000;
  localparam int HIST_DEPTH = 4;
  // ----------------------------------------
  // registers (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_OSPD = 8'h04;
  localparam logic [7:0] A_DEVLIM = 8'h08;
  localparam logic [7:0] A_BRKPCT = 8'h0c;
  localparam logic [7:0] A_RATED = 8'h10;
  localparam logic [7:0] A_NOLOAD = 8'h14;
  localparam logic [7:0] A_PIDLVL = 8'h18;
  localparam logic [7:0] A_ENCPER = 8'h1c;
  localparam logic [7:0] A_PIDPER = 8'h20;
  localparam logic [7:0] A_TRIPS = 8'h24;
  localparam logic [7:0] A_ISTS = 8'h28;
  localparam logic [7:0] A_ICLR = 8'h2c;
  localparam logic [7:0] A_IEN = 8'h30;
  localparam logic [7:0] A_HIST = 8'h34;
  // cfg fields
  localparam int F_FAN = 0;
  localparam int F_THM = 1;
  localparam int F_DEVEN = 3;
  localparam int F_ENCEN = 4;
  localparam int F_KPD = 5;
  localparam int F_CMD = 7;
  localparam int F_MODE = 9;
  localparam int F_BRKO = 11;
  localparam int F_B22 = 12;
  localparam int F_HISTEN = 13;
  localparam int F_SIGEN = 14;
  localparam int F_SRST = 15;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] LVL_RST = 16'hffff;
  localparam logic [31:0] PER_RST = 32'h0000_03e8;
  localparam logic [1:0] MODE_VEC = 2'h3;
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_KHZ = 250000;
  localparam longint KPD_LOSS_MS = 2000;
  localparam longint BRK_LOW_MS = 10000;
  localparam longint KPD_LOSS_CYC = KPD_LOSS_MS * CLK_KHZ;
  localparam longint BRK_LOW_CYC = BRK_LOW_MS * CLK_KHZ;
endpackage

// [core/dftm_tmr_if.sv]
/*
  interface between the trip manager and its persistence timers.
  assumes all users sit on the same clock.
*/
`timescale 1ns/1ps
interface dftm_tmr_if #(parameter int N = 4, parameter int W = 32);
  logic [N-1:0] cond;
  logic [N-1:0][W-1:0] limit;
  logic [N-1:0] expired;
  modport mgr (output cond, output limit, input expired);
  modport tmr (input cond, input limit, output expired);
endinterface

// [core/dftm_sync.sv]
/*
  three-stage synchroniser for a vector of pin levels.
  a bit changes only once stages two and three agree.
*/
`timescale 1ns/1ps
module dftm_sync #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_lvl
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dftm_sync_s;
  dftm_sync_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_lvl = st_reg.q;
endmodule

// [core/dftm_persist.sv]
/*
  bank of persistence timers: a flag rises once its condition has held
  for limit + 1 cycles without a break. any break restarts the count.
*/
`timescale 1ns/1ps
module dftm_persist #(
  parameter int N = 4,
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  dftm_tmr_if.tmr tif
);
  typedef struct packed {
    logic [N-1:0][W-1:0] cnt;
    logic [N-1:0] exp;
  } dftm_pers_s;
  dftm_pers_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < N; i++) begin
      if (!tif.cond[i]) begin
        st_next.cnt[i] = '0;
        st_next.exp[i] = 1'b0;
      end else if (st_reg.cnt[i] >= tif.limit[i]) begin
        st_next.exp[i] = 1'b1;
      end else begin
        st_next.cnt[i] = st_reg.cnt[i] + W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.expired = st_reg.exp;
endmodule

// [core/dftm_trip_mgr.sv]
/*
  drive fault trip manager: turns fault conditions into level, latched
  and fatal trips, logs history, raises an interrupt and a trip output.
  assumes a 250 MHz clock, power-on reset on i_rstn, measurements from
  logic on the same clock and fault pins from outside it.
*/
// Operation
// - level trips follow their condition and are never logged
// - latched trips clear only by reset pulse after the condition is gone; a pulled option module clears with the pulse
// - fatal trips survive reset pulses; only power cycling clears them
// - fan fault trips only when fan action is 0 and rating below 22 kW
// - thermistor over-resistance trips only when thermistor selection is nonzero
// - overspeed trips when speed exceeds the overspeed level
// - speed deviation trips beyond the limit while the check is enabled
// - encoder wiring trips after abnormality persists for the set period
// - pre-PID low feedback held for the set period trips as load fault
// - scalar modes: brake current low for ten seconds trips the brake
// - vector mode: current below half no-load current trips the brake
// - keypad loss gives a level trip two seconds after link loss
// - command loss gives a level trip while running from other sources
// - each option slot trips on removal or silence after installation
// - I/O board disconnection or connection fault trips
// - keypad failure during a parameter write trips
// - open or faulty power stage temperature sensor trips
// - history and fault signal output are skipped when not enabled
`timescale 1ns/1ps
module dftm_trip_mgr
  import dftm_pkg::*;
#(
  parameter logic [31:0] P_KPD_CYC = 32'(KPD_LOSS_CYC),
  parameter logic [31:0] P_BRK_CYC = 32'(BRK_LOW_CYC)
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_speed,
  input wire logic [15:0] i_speed_dev,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_pid_feedback,
  input wire logic i_prepid_active,
  input wire logic i_running,
  input wire logic i_keypad_cmd_src,
  input wire logic i_param_write_busy,
  input wire logic i_fan_fault,
  input wire logic i_therm_over,
  input wire logic i_enc_abnormal,
  input wire logic i_keypad_link_lost,
  input wire logic i_cmd_fail,
  input wire logic [2:0] i_opt_present,
  input wire logic [2:0] i_opt_comm_fail,
  input wire logic i_io_board_fault,
  input wire logic i_power_temp_sensor_fault,
  input wire logic i_hw_diag_fault,
  input wire logic i_fault_reset,
  output logic [31:0] o_rdata,
  output logic [15:0] o_trips,
  output logic o_trip,
  output logic o_fault_relay,
  output logic o_irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NP = 15;
  logic [NP-1:0] pin;
  logic p_fan, p_thm, p_enc, p_kpl, p_cmd, p_iob, p_ntc, p_hwd, p_rst;
  logic [2:0] p_opt, p_ofail;

  dftm_sync #(.W(NP)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin({i_fan_fault, i_therm_over, i_enc_abnormal, i_keypad_link_lost,
            i_cmd_fail, i_opt_present, i_opt_comm_fail, i_io_board_fault,
            i_power_temp_sensor_fault, i_hw_diag_fault, i_fault_reset}),
    .o_lvl(pin)
  );
  assign {p_fan, p_thm, p_enc, p_kpl, p_cmd, p_opt, p_ofail, p_iob, p_ntc,
          p_hwd, p_rst} = pin;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] ospd;
    logic [15:0] devlim;
    logic [15:0] brkpct;
    logic [15:0] rated;
    logic [15:0] noload;
    logic [15:0] pidlvl;
    logic [31:0] encper;
    logic [31:0] pidper;
    logic [NTRIP-1:0] trips;
    logic [NTRIP-1:0] sts;
    logic [NTRIP-1:0] en;
    logic [2:0] armed;
    logic rst_q;
    logic [HIST_DEPTH-1:0][4:0] hist;
    logic [1:0] hptr;
    logic [2:0] hcnt;
    logic [31:0] rdata;
    logic irq;
    logic any;
    logic relay;
  } dftm_state_s;
  dftm_state_s st_reg, st_next;

  dftm_tmr_if #(.N(4), .W(32)) tif ();

  dftm_persist #(.N(4), .W(32)) u_persist (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .tif(tif.tmr)
  );

  // lowest set bit as a trip code, for the history log
  function automatic logic [4:0] first_trip(input logic [NTRIP-1:0] v);
    logic [4:0] c;
    c = '0;
    for (int i = NTRIP - 1; i >= 0; i--) begin
      if (v[i]) begin
        c = 5'(i);
      end
    end
    return c;
  endfunction

  // ----------------------------------------
  // fault conditions
  // ----------------------------------------
  logic [15:0] cfg;
  logic scalar, vec, brk_low;
  logic [NTRIP-1:0] cond;
  logic [NTRIP-1:0] clr_ok;
  logic rst_pulse;

  assign cfg = st_reg.cfg;
  assign vec = cfg[F_MODE +: 2] == MODE_VEC;
  assign scalar = !vec;
  // product avoids a divider; both sides in current units times percent
  assign brk_low = ({16'h0000, i_out_current} * PCT_FULL) <
                   ({16'h0000, st_reg.brkpct} * {16'h0000, st_reg.rated});
  assign rst_pulse = (p_rst && !st_reg.rst_q) || (i_wr && i_addr == A_CFG && i_wdata[F_SRST]);

  always_comb begin
    tif.cond[0] = cfg[F_ENCEN] && p_enc;
    tif.cond[1] = i_prepid_active && i_pid_feedback < st_reg.pidlvl;
    tif.cond[2] = scalar && cfg[F_BRKO] && brk_low;
    tif.cond[3] = cfg[F_KPD +: 2] != 2'h0 && i_keypad_cmd_src && p_kpl;
    tif.limit[0] = st_reg.encper;
    tif.limit[1] = st_reg.pidper;
    tif.limit[2] = P_BRK_CYC;
    tif.limit[3] = P_KPD_CYC;
  end

  always_comb begin
    cond = '0;
    cond[T_FAN] = p_fan && !cfg[F_FAN] && cfg[F_B22];
    cond[T_THM] = p_thm && cfg[F_THM +: 2] != 2'h0;
    cond[T_OSPD] = i_speed > st_reg.ospd;
    cond[T_DEV] = cfg[F_DEVEN] && i_speed_dev > st_reg.devlim;
    cond[T_ENC] = tif.expired[0];
    cond[T_PID] = tif.expired[1];
    cond[T_BRK] = tif.expired[2] ||
                  (vec && cfg[F_BRKO] && i_out_current < (st_reg.noload >> 1));
    cond[T_KPD] = tif.expired[3];
    cond[T_CMD] = cfg[F_CMD +: 2] != 2'h0 && i_running && !i_keypad_cmd_src
                  && p_cmd;
    for (int s = 0; s < 3; s++) begin
      // an empty slot that sees the reset pulse is being disarmed, not tripped again
      cond[T_OPT1 + s] = st_reg.armed[s] && !(rst_pulse && !p_opt[s])
                         && (!p_opt[s] || p_ofail[s]);
    end
    cond[T_IOB] = p_iob;
    cond[T_PRM] = i_param_write_busy && p_kpl;
    cond[T_NTC] = p_ntc;
    cond[T_HWD] = p_hwd;
    // a pulled module counts as acknowledged by the reset pulse
    clr_ok = ~cond;
    for (int s = 0; s < 3; s++) begin
      clr_ok[T_OPT1 + s] = !p_ofail[s];
    end
  end

  // ----------------------------------------
  // trips, history, interrupt, registers
  // ----------------------------------------
  logic [NTRIP-1:0] new_trips;

  always_comb begin
    st_next = st_reg;
    st_next.rst_q = p_rst;
    for (int s = 0; s < 3; s++) begin
      // arming needs a module seen after power-up; reset disarms empty slots
      st_next.armed[s] = p_opt[s] || (st_reg.armed[s] && !(rst_pulse && !p_opt[s]));
    end
    for (int i = 0; i < NTRIP; i++) begin
      if (LEVEL_MASK[i]) begin
        st_next.trips[i] = cond[i];
      end else if (FATAL_MASK[i]) begin
        st_next.trips[i] = cond[i] || st_reg.trips[i];
      end else begin
        st_next.trips[i] = cond[i] || (st_reg.trips[i] && !(rst_pulse && clr_ok[i]));
      end
    end
    new_trips = st_next.trips & ~st_reg.trips;
    if (cfg[F_HISTEN] && |(new_trips & ~LEVEL_MASK)) begin
      st_next.hist[st_reg.hptr] = first_trip(new_trips & ~LEVEL_MASK);
      st_next.hptr = st_reg.hptr + 2'h1;
      if (st_reg.hcnt != 3'(HIST_DEPTH)) begin
        st_next.hcnt = st_reg.hcnt + 3'h1;
      end
    end
    st_next.rdata = '0;
    if (i_wr) begin
      unique case (i_addr)
        A_CFG: st_next.cfg = {1'b0, i_wdata[14:0]};
        A_OSPD: st_next.ospd = i_wdata[15:0];
        A_DEVLIM: st_next.devlim = i_wdata[15:0];
        A_BRKPCT: st_next.brkpct = i_wdata[15:0];
        A_RATED: st_next.rated = i_wdata[15:0];
        A_NOLOAD: st_next.noload = i_wdata[15:0];
        A_PIDLVL: st_next.pidlvl = i_wdata[15:0];
        A_ENCPER: st_next.encper = i_wdata;
        A_PIDPER: st_next.pidper = i_wdata;
        A_IEN: st_next.en = i_wdata[15:0];
        default: ;
      endcase
    end
    // new events win over a clear in the same cycle
    st_next.sts = (st_reg.sts & ~((i_wr && i_addr == A_ICLR) ? i_wdata[15:0] : 16'h0000))
                  | new_trips;
    if (i_rd) begin
      unique case (i_addr)
        A_CFG: st_next.rdata = {16'h0000, st_reg.cfg};
        A_OSPD: st_next.rdata = {16'h0000, st_reg.ospd};
        A_DEVLIM: st_next.rdata = {16'h0000, st_reg.devlim};
        A_BRKPCT: st_next.rdata = {16'h0000, st_reg.brkpct};
        A_RATED: st_next.rdata = {16'h0000, st_reg.rated};
        A_NOLOAD: st_next.rdata = {16'h0000, st_reg.noload};
        A_PIDLVL: st_next.rdata = {16'h0000, st_reg.pidlvl};
        A_ENCPER: st_next.rdata = st_reg.encper;
        A_PIDPER: st_next.rdata = st_reg.pidper;
        A_TRIPS: st_next.rdata = {16'h0000, st_reg.trips};
        A_ISTS: st_next.rdata = {16'h0000, st_reg.sts};
        A_IEN: st_next.rdata = {16'h0000, st_reg.en};
        A_HIST: st_next.rdata = {7'h00, st_reg.hptr, st_reg.hcnt, st_reg.hist};
        default: st_next.rdata = '0;
      endcase
    end
    st_next.irq = |(st_next.sts & st_next.en);
    st_next.any = |st_next.trips;
    st_next.relay = st_next.any && cfg[F_SIGEN];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
      st_reg.cfg <= CFG_RST;
      st_reg.ospd <= LVL_RST;
      st_reg.devlim <= LVL_RST;
      st_reg.encper <= PER_RST;
      st_reg.pidper <= PER_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_trips = st_reg.trips;
  assign o_trip = st_reg.any;
  assign o_fault_relay = st_reg.relay;
  assign o_irq = st_reg.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_level_follow: assert property (!cond[T_CMD] |=> !o_trips[T_CMD])
    else $error("level trip outlived its condition");
  a_latch_hold: assert property (o_trips[T_OSPD] && !rst_pulse |=> o_trips[T_OSPD])
    else $error("latched trip cleared without reset pulse");
  a_fatal_sticky: assert property (o_trips[T_HWD] |=> o_trips[T_HWD])
    else $error("fatal trip cleared before power cycle");
  a_fan_gate: assert property ((cfg[F_FAN] || !cfg[F_B22]) && !o_trips[T_FAN]
    |=> !o_trips[T_FAN])
    else $error("fan trip raised while disabled");
  a_therm_gate: assert property (cfg[F_THM +: 2] == 2'h0 && !o_trips[T_THM]
    |=> !o_trips[T_THM])
    else $error("thermistor trip raised while disabled");
  a_ospd_set: assert property (i_speed > st_reg.ospd |=> o_trips[T_OSPD])
    else $error("overspeed not tripped");
  a_dev_set: assert property (cfg[F_DEVEN] && i_speed_dev > st_reg.devlim
    |=> o_trips[T_DEV])
    else $error("speed deviation not tripped");
  a_vec_brake: assert property (vec && cfg[F_BRKO] && i_out_current < (st_reg.noload >> 1)
    |=> o_trips[T_BRK])
    else $error("vector brake trip missing");
  a_enc_wait: assert property ($rose(tif.expired[0]) |-> $past(tif.cond[0], 2))
    else $error("encoder trip without persistence");
  a_any_trip: assert property (o_trip == (o_trips != 16'h0000))
    else $error("combined trip output wrong");
  a_irq_level: assert property (o_irq == ((st_reg.sts & st_reg.en) != 16'h0000))
    else $error("interrupt level wrong");
  a_kpd_level: assert property (!cond[T_KPD] |=> !o_trips[T_KPD])
    else $error("keypad loss trip outlived its condition");
  a_fan_set: assert property (p_fan && !cfg[F_FAN] && cfg[F_B22] |=> o_trips[T_FAN])
    else $error("fan trip missing");
  a_thm_set: assert property (p_thm && cfg[F_THM +: 2] != 2'h0 |=> o_trips[T_THM])
    else $error("thermistor trip missing");
  a_iob_set: assert property (p_iob |=> o_trips[T_IOB])
    else $error("io board trip missing");
  a_prm_set: assert property (i_param_write_busy && p_kpl |=> o_trips[T_PRM])
    else $error("parameter write trip missing");
  a_ntc_set: assert property (p_ntc |=> o_trips[T_NTC])
    else $error("power stage sensor trip missing");
  a_opt_clear: assert property (rst_pulse && !p_opt[1] && !p_ofail[1]
    |=> !o_trips[T_OPT1 + 1])
    else $error("empty slot trip survived the reset pulse");
  a_hist_skip: assert property (!cfg[F_HISTEN] |=> $stable(st_reg.hist))
    else $error("history written while disabled");
  a_level_nolog: assert property ((new_trips & ~LEVEL_MASK) == 16'h0000
    |=> $stable(st_reg.hist))
    else $error("level trip logged in history");
  a_relay_gate: assert property (!cfg[F_SIGEN] |=> !o_fault_relay)
    else $error("fault relay driven while disabled");
  a_sts_set: assert property (new_trips[T_OSPD] |=> st_reg.sts[T_OSPD])
    else $error("status bit missed a new trip");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  c_latch_clear: cover property (o_trips[T_OSPD] ##1 !o_trips[T_OSPD]);
  c_fatal_set: cover property ($rose(o_trips[T_HWD]));
  c_level_drop: cover property (o_trips[T_KPD] ##1 !o_trips[T_KPD]);
  c_irq_rise: cover property ($rose(o_irq));
endmodule

// [bench/dftm_far_model.sv]
/*
  operator-side model: keypad, terminal block and option modules.
  turns commanded fault levels into pin levels and makes the fault reset
  pulse. assumes the bench commands it on the rising edge of i_clk.
*/
`timescale 1ns/1ps
module dftm_far_model (
  input wire logic i_clk,
  input wire logic i_reset_req,
  input wire logic [13:0] i_fault_cmd,
  output logic [13:0] o_fault_pins,
  output logic o_fault_reset
);
  // ----------------------------------------
  // pins and reset pulse
  // ----------------------------------------
  logic [2:0] stretch_reg = 3'h0;
  // pins change only on the edge, like a sampled terminal block
  always @(posedge i_clk) begin
    o_fault_pins <= i_fault_cmd;
    if (i_reset_req) begin
      stretch_reg <= 3'h4;
    end else if (stretch_reg != 3'h0) begin
      stretch_reg <= stretch_reg - 3'h1;
    end
  end
  // four cycles wide so the three-flop synchroniser cannot miss it
  assign o_fault_reset = (stretch_reg != 3'h0);
endmodule

// [bench/test_drive_fault_trip_manager.sv]
/*
  self-checking bench for the trip manager: table of trip cases, irq and
  fatal trip with power cycle. assumes the far side model and short timers.
*/
`timescale 1ns/1ps
module test_drive_fault_trip_manager
  import dftm_pkg::*;
();
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_clk, i_rstn, i_wr, i_rd, prepid, running, kpd_src, prm_busy, rst_req, freset;
  logic o_trip, o_fault_relay, o_irq;
  logic [7:0] addr;
  logic [31:0] wdata, o_rdata, v;
  logic [15:0] speed, sdev, cur, pidfb, o_trips;
  logic [13:0] fcmd, pins;
  int n_errors, checks;
  localparam int TBIT [14] = '{T_KPD, T_CMD, T_OSPD, T_DEV, T_ENC, T_PID, T_BRK, T_BRK,
    T_OPT1, T_IOB, T_PRM, T_NTC, T_THM, T_FAN};
  localparam logic [15:0] TCFG [14] = '{16'h0020, 16'h0080, 16'h0000, 16'h0008, 16'h0010,
    16'h0000, 16'h0800, 16'h0e00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h1000};
  // ffff: case skips the run with its enable withheld
  localparam logic [15:0] NEG [14] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0000, 16'h1001};

  dftm_far_model u_far (.i_clk(i_clk), .i_reset_req(rst_req), .i_fault_cmd(fcmd),
    .o_fault_pins(pins), .o_fault_reset(freset));

  dftm_trip_mgr #(.P_KPD_CYC(32'h0000_0014), .P_BRK_CYC(32'h0000_0032)) u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_speed(speed), .i_speed_dev(sdev), .i_out_current(cur),
    .i_pid_feedback(pidfb), .i_prepid_active(prepid), .i_running(running),
    .i_keypad_cmd_src(kpd_src), .i_param_write_busy(prm_busy), .i_fan_fault(pins[0]),
    .i_therm_over(pins[1]), .i_enc_abnormal(pins[2]), .i_keypad_link_lost(pins[3]),
    .i_cmd_fail(pins[4]), .i_opt_present(pins[7:5]), .i_opt_comm_fail(pins[10:8]),
    .i_io_board_fault(pins[11]), .i_power_temp_sensor_fault(pins[12]),
    .i_hw_diag_fault(pins[13]), .i_fault_reset(freset), .o_rdata(o_rdata),
    .o_trips(o_trips), .o_trip(o_trip), .o_fault_relay(o_fault_relay), .o_irq(o_irq));

  always #2 i_clk = ~i_clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask
  task automatic pulse();
    @(posedge i_clk);
    rst_req <= 1'b1;
    @(posedge i_clk);
    rst_req <= 1'b0;
    cyc(12);
  endtask
  task automatic apply(input int k, input logic on);
    @(posedge i_clk);
    kpd_src <= (k == 0);
    case (k)
      0: fcmd[3] <= on;
      1: fcmd[4] <= on;
      2: speed <= on ? 16'h0065 : 16'h0000;
      3: sdev <= on ? 16'h0033 : 16'h0000;
      4: fcmd[2] <= on;
      5: begin
        prepid <= on;
        pidfb <= on ? 16'h0032 : 16'h00c8;
      end
      6, 7: cur <= on ? 16'h000a : 16'h0064;
      8: fcmd[5] <= !on;
      9: fcmd[11] <= on;
      10: begin
        prm_busy <= on;
        fcmd[3] <= on;
      end
      11: fcmd[12] <= on;
      12: fcmd[1] <= on;
      default: fcmd[0] <= on;
    endcase
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    speed = 16'h0;
    sdev = 16'h0;
    cur = 16'h0064;
    pidfb = 16'h00c8;
    prepid = 1'b0;
    running = 1'b1;
    kpd_src = 1'b0;
    prm_busy = 1'b0;
    rst_req = 1'b0;
    fcmd = 14'h00e0;
    n_errors = 0;
    checks = 0;
    cyc(16);
    i_rstn <= 1'b1;
    wr(A_OSPD, 32'h64);
    wr(A_DEVLIM, 32'h32);
    wr(A_BRKPCT, 32'h32);
    wr(A_RATED, 32'h64);
    wr(A_NOLOAD, 32'h28);
    wr(A_PIDLVL, 32'h64);
    wr(A_ENCPER, 32'ha);
    wr(A_PIDPER, 32'ha);
    for (int k = 0; k < 14; k++) begin
      if (NEG[k] != 16'hffff) begin
        wr(A_CFG, {16'h0, NEG[k]});
        apply(k, 1'b1);
        cyc(80);
        rdc(A_TRIPS, 32'h0);
        apply(k, 1'b0);
        cyc(10);
      end
      wr(A_CFG, {16'h0, TCFG[k] | 16'h6000});
      apply(k, 1'b1);
      if (k == 0 || k == 6) begin
        cyc(8);
        rdc(A_TRIPS, 32'h0);
      end
      cyc(80);
      rdc(A_TRIPS, 32'h1 << TBIT[k]);
      check(o_trip, 1'b1);
      check(o_fault_relay, 1'b1);
      // an empty slot counts as gone, so that pulse would disarm instead
      if (!LEVEL_MASK[TBIT[k]] && k != 8) begin
        pulse();
        rdc(A_TRIPS, 32'h1 << TBIT[k]);
      end
      apply(k, 1'b0);
      cyc(10);
      if (!LEVEL_MASK[TBIT[k]]) begin
        rdc(A_TRIPS, 32'h1 << TBIT[k]);
        pulse();
      end
      rdc(A_TRIPS, 32'h0);
      check(o_trip, 1'b0);
      if (k == 1) rdc(A_HIST, 32'h0);
      $display("test trip case %0d done", k);
    end
    rdc(A_HIST, {9'h0, 3'h4, 5'h00, 5'h01, 5'h0e, 5'h0d});
    // slot 2 pulled, slot 3 silent; the pulse clears and disarms only the empty slot
    @(posedge i_clk);
    fcmd[6] <= 1'b0;
    fcmd[10] <= 1'b1;
    cyc(10);
    rdc(A_TRIPS, 32'h0c00);
    pulse();
    rdc(A_TRIPS, 32'h0800);
    @(posedge i_clk);
    fcmd[6] <= 1'b1;
    fcmd[10] <= 1'b0;
    cyc(10);
    rdc(A_TRIPS, 32'h0800);
    pulse();
    rdc(A_TRIPS, 32'h0);
    $display("test option slots done");
    rdc(A_ISTS, 32'h7fff);
    wr(A_IEN, 32'h4);
    cyc(2);
    check(o_irq, 1'b1);
    wr(A_ICLR, 32'h4);
    cyc(2);
    check(o_irq, 1'b0);
    rdc(A_ISTS, 32'h7ffb);
    $display("test irq done");
    wr(A_CFG, 32'h0);
    @(posedge i_clk);
    fcmd[13] <= 1'b1;
    cyc(10);
    rdc(A_TRIPS, 32'h8000);
    check(o_fault_relay, 1'b0);
    @(posedge i_clk);
    fcmd[13] <= 1'b0;
    cyc(10);
    pulse();
    wr(A_CFG, 32'h8000);
    cyc(4);
    rdc(A_TRIPS, 32'h8000);
    check(o_trip, 1'b1);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    cyc(4);
    i_rstn <= 1'b1;
    rdc(A_TRIPS, 32'h0);
    rdc(A_OSPD, 32'hffff);
    rdc(A_ENCPER, 32'h3e8);
    rdc(A_ISTS, 32'h0);
    rdc(8'h3c, 32'h0);
    check(o_trip, 1'b0);
    $display("test fatal done");
    give_verdict();
  end

  // the tests need about 2,500 cycles; 30,000 means a hang
  initial begin
    #120000;
    n_errors++;
    give_verdict();
  end
endmodule
